// *** hdl/osc_pkg.sv ***
// Package of constants and types for the oversampling conversion control block.
package osc_pkg;

    // Number of channels and width of one conversion result.
    localparam int OSC_CHANNELS = 8;
    localparam int OSC_DATA_W = 14;

    // Width of the ratio select and of the accumulator (14 bits plus log2 of 64).
    localparam int OSC_SEL_W = 3;
    localparam int OSC_ACC_W = 20;

    // Ratio select codes at the edges of the table.
    localparam logic [2:0] OSC_SEL_NONE = 3'h0;
    localparam logic [2:0] OSC_SEL_MAX = 3'h6;
    localparam logic [2:0] OSC_SEL_INVALID = 3'h7;

    // Time of one single conversion, ns, and its cycle count at 100 MHz.
    localparam int OSC_CONV_NS = 4000;
    localparam int OSC_CLK_NS = 10;
    localparam int OSC_CONV_CYC = (OSC_CONV_NS + OSC_CLK_NS - 1) / OSC_CLK_NS;
    localparam int OSC_CNT_W = 16;

    // Reset values.
    localparam logic [2:0] OSC_SEL_RESET = 3'h0;
    localparam logic [OSC_DATA_W-1:0] OSC_DATA_RESET = 14'h0000;

    // Sequencer states.
    typedef enum logic [1:0] {OSC_IDLE, OSC_CONVERT, OSC_PACE} osc_state_e;

    // Log2 of the ratio for a select code; invalid or none both mean one sample.
    function automatic logic [2:0] osc_shift(input logic [2:0] sel);
        if (sel == OSC_SEL_INVALID)
        begin
            return 3'h0;
        end
        return sel;
    endfunction : osc_shift

endpackage : osc_pkg

// *** hdl/osc_sync.sv ***
// Two flip-flop synchroniser for one asynchronous pin level.
module osc_sync
    import osc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic async_i,
    output logic sync_o
);

    // First stage, read only by the second stage.
    logic meta;
    // Second stage, safe for any logic.
    logic stable;

    // Both stages clear to zero on reset.
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            meta <= 1'b0;
            stable <= 1'b0;
        end
        else
        begin
            meta <= async_i;
            stable <= meta;
        end
    end

    assign sync_o = stable;

endmodule : osc_sync

// *** hdl/osc_control.sv ***
// Oversampling conversion sequencer: start edge, burst, busy, averaging and output update.
// Function
// - First sample on start edge, rest internally paced.
// - Busy high whole burst, longer at higher ratio.
// - Output registers load on busy falling edge.
// - Previous results readable while busy high.
// - Select 000 none, 001-110 ratios, 111 invalid.
// - Ratio select latched on busy falling edge.
module osc_control
    import osc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic SAMPLE_START_A_I,
    input wire logic SAMPLE_START_B_I,
    input wire logic [OSC_SEL_W-1:0] RATIO_SELECT_I,
    input wire logic [OSC_CHANNELS*OSC_DATA_W-1:0] SAMPLE_DATA_I,
    input wire logic [2:0] CHANNEL_SEL_I,
    output logic SAMPLE_STROBE_O,
    output logic BUSY_O,
    output logic [OSC_SEL_W-1:0] ACTIVE_RATIO_O,
    output logic [OSC_DATA_W-1:0] RESULT_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.

    // Synchronised start pins and ratio select.
    logic start_a_sync;
    logic start_b_sync;
    logic [OSC_SEL_W-1:0] sel_sync;
    // Previous combined start level for edge detection.
    logic start_prev;
    logic next_start_prev;
    // Combined start and its rising edge.
    logic start_lvl;
    logic start_rise;

    osc_sync u_sync_a (.CLK_I(CLK_I), .RESET_I(RESET_I), .async_i(SAMPLE_START_A_I),
                       .sync_o(start_a_sync));
    osc_sync u_sync_b (.CLK_I(CLK_I), .RESET_I(RESET_I), .async_i(SAMPLE_START_B_I),
                       .sync_o(start_b_sync));

    // The select bus is static in use, so each bit is synchronised alone.
    genvar gi;
    generate
        for (gi = 0; gi < OSC_SEL_W; gi++)
        begin : g_sel
            osc_sync u_sync_sel (.CLK_I(CLK_I), .RESET_I(RESET_I),
                                 .async_i(RATIO_SELECT_I[gi]), .sync_o(sel_sync[gi]));
        end
    endgenerate

    // Both pins are expected to move together; requiring both guards a skewed pair.
    always_comb
    begin
        start_lvl = start_a_sync & start_b_sync;
        start_rise = start_lvl & ~start_prev;
        next_start_prev = start_lvl;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer state.

    osc_state_e state;
    osc_state_e next_state;
    // Cycle counter within one conversion.
    logic [OSC_CNT_W-1:0] cnt;
    logic [OSC_CNT_W-1:0] next_cnt;
    // Samples still to take after the current one.
    logic [6:0] left;
    logic [6:0] next_left;
    // Ratio in force for this burst, latched when busy falls.
    logic [OSC_SEL_W-1:0] ratio;
    logic [OSC_SEL_W-1:0] next_ratio;
    // One-cycle internal sample strobe.
    logic strobe;
    logic next_strobe;
    // High in the cycle the burst finishes; output and select update then.
    logic finish;

    // Next-state logic of the sequencer.
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_left = left;
        next_ratio = ratio;
        next_strobe = 1'b0;
        finish = 1'b0;
        unique case (state)
            OSC_IDLE:
            begin
                // A start edge during a burst is ignored: the host keeps the rate down.
                if (start_rise)
                begin
                    next_state = OSC_CONVERT;
                    next_strobe = 1'b1;
                    next_cnt = '0;
                    next_left = 7'((7'h1 << osc_shift(ratio)) - 7'h1);
                end
            end
            OSC_CONVERT:
            begin
                // Each conversion lasts the same time, so busy scales with ratio.
                if (cnt == OSC_CNT_W'(OSC_CONV_CYC - 1))
                begin
                    if (left == 7'h0)
                    begin
                        finish = 1'b1;
                        next_state = OSC_IDLE;
                        next_ratio = sel_sync;
                    end
                    else
                    begin
                        next_state = OSC_PACE;
                    end
                end
                else
                begin
                    next_cnt = OSC_CNT_W'(cnt + 1'b1);
                end
            end
            OSC_PACE:
            begin
                // Internally generated strobe for the remaining samples.
                next_state = OSC_CONVERT;
                next_strobe = 1'b1;
                next_cnt = '0;
                next_left = 7'(left - 7'h1);
            end
        endcase
    end

    // Registers of the sequencer.
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            state <= OSC_IDLE;
            cnt <= '0;
            left <= '0;
            ratio <= OSC_SEL_RESET;
            strobe <= 1'b0;
            start_prev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            left <= next_left;
            ratio <= next_ratio;
            strobe <= next_strobe;
            start_prev <= next_start_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Accumulation and output registers.

    // Running sums, one per channel.
    logic [OSC_ACC_W-1:0] acc [OSC_CHANNELS];
    logic [OSC_ACC_W-1:0] next_acc [OSC_CHANNELS];
    // Output data registers.
    logic [OSC_DATA_W-1:0] dout [OSC_CHANNELS];
    logic [OSC_DATA_W-1:0] next_dout [OSC_CHANNELS];

    // Samples are two's complement; they are sign extended, summed and shifted down.
    always_comb
    begin
        logic [OSC_ACC_W-1:0] total;
        total = '0;
        for (int c = 0; c < OSC_CHANNELS; c++)
        begin
            next_acc[c] = acc[c];
            next_dout[c] = dout[c];
            // The sample is valid in the cycle the strobe is high; sum it then.
            if (strobe)
            begin
                next_acc[c] = OSC_ACC_W'(acc[c] + OSC_ACC_W'($signed(
                    SAMPLE_DATA_I[c*OSC_DATA_W +: OSC_DATA_W])));
                if (left == next_left && state == OSC_CONVERT && cnt == '0 &&
                    osc_shift(ratio) == 3'h0)
                begin
                    next_acc[c] = OSC_ACC_W'($signed(
                        SAMPLE_DATA_I[c*OSC_DATA_W +: OSC_DATA_W]));
                end
            end
            if (finish)
            begin
                total = OSC_ACC_W'($signed(acc[c]) >>> osc_shift(ratio));
                next_dout[c] = total[OSC_DATA_W-1:0];
                next_acc[c] = '0;
            end
        end
    end

    // Output and accumulator registers.
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            for (int c = 0; c < OSC_CHANNELS; c++)
            begin
                acc[c] <= '0;
                dout[c] <= OSC_DATA_RESET;
            end
        end
        else
        begin
            acc <= next_acc;
            dout <= next_dout;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Results stay readable during a burst; they change only as busy falls.
    assign RESULT_O = dout[CHANNEL_SEL_I];
    assign BUSY_O = (state != OSC_IDLE);
    assign SAMPLE_STROBE_O = strobe;
    assign ACTIVE_RATIO_O = ratio;

endmodule : osc_control

// *** tb/osc_host_model.sv ***
// Host-side model: drives both start pins as one and feeds channel samples.
module osc_host_model
    import osc_pkg::*;
(
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic busy_i,
    input wire logic strobe_i,
    output logic start_o,
    output logic [OSC_CHANNELS*OSC_DATA_W-1:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Start pulse length counter, strobe delay line and sample parity.
    logic [2:0] hold = 3'h0;
    logic [2:0] dly = 3'h0;
    logic par = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // A start is only issued while idle, so the rate falls with the ratio.
    always_ff @(posedge clk_i)
    begin
        dly <= {dly[1:0], strobe_i};
        if (go_i && !busy_i && hold == 3'h0)
        begin
            hold <= 3'h4;
        end
        else if (hold != 3'h0)
        begin
            hold <= hold - 3'h1;
        end
        // Parity moves well after each strobe, so each sample sees a settled value.
        par <= go_i ? 1'b0 : par ^ dly[2];
    end

    // One level feeds both start pins, so their edges coincide.
    assign start_o = (hold != 3'h0);

    // Samples alternate by two per strobe, so an even burst averages to base plus one.
    always_comb
    begin
        for (int c = 0; c < OSC_CHANNELS; c++)
        begin
            data_o[c*OSC_DATA_W +: OSC_DATA_W] = OSC_DATA_W'(c * 256 + 16 + 2 * int'(par));
        end
    end
endmodule : osc_host_model

// *** tb/osc_control_properties.sv ***
// Port checker for the oversampling sequencer.
module osc_control_checker
    import osc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic SAMPLE_START_A_I,
    input wire logic SAMPLE_START_B_I,
    input wire logic [2:0] CHANNEL_SEL_I,
    input wire logic SAMPLE_STROBE_O,
    input wire logic BUSY_O,
    input wire logic [OSC_SEL_W-1:0] ACTIVE_RATIO_O,
    input wire logic [OSC_DATA_W-1:0] RESULT_O
);
    timeunit 1ns;
    timeprecision 1ps;

    // All properties run on the block clock and rest while reset is high.
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    ////////////////////////////////////////////////////////////////////////
    property p_first;
        $rose(SAMPLE_START_A_I && SAMPLE_START_B_I) && !BUSY_O |-> ##3 SAMPLE_STROBE_O;
    endproperty
    a_first: assert property (p_first) else $error("first strobe not on time");
    property p_pulse;
        SAMPLE_STROBE_O |=> !SAMPLE_STROBE_O [*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("strobe too long");
    property p_busy_rise;
        $rose(BUSY_O) |-> SAMPLE_STROBE_O;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy rose without strobe");
    property p_busy_strobe;
        SAMPLE_STROBE_O |-> BUSY_O;
    endproperty
    a_busy_strobe: assert property (p_busy_strobe) else $error("strobe outside busy");
    property p_busy_min;
        $rose(BUSY_O) |-> BUSY_O [*8];
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    property p_ratio_hold;
        !$fell(BUSY_O) |-> $stable(ACTIVE_RATIO_O);
    endproperty
    a_ratio_hold: assert property (p_ratio_hold) else $error("ratio moved off busy fall");
    property p_result_hold;
        !$fell(BUSY_O) && $stable(CHANNEL_SEL_I) |-> $stable(RESULT_O);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved");

    // Main scenarios reached.
    c_fall: cover property ($fell(BUSY_O));
    c_invalid: cover property ($fell(BUSY_O) ##1 ACTIVE_RATIO_O == OSC_SEL_INVALID);
    c_max: cover property ($fell(BUSY_O) ##1 ACTIVE_RATIO_O == OSC_SEL_MAX);
endmodule : osc_control_checker

bind osc_control osc_control_checker i_osc_control_checker (.CLK_I(CLK_I), .RESET_I(RESET_I),
    .SAMPLE_START_A_I(SAMPLE_START_A_I), .SAMPLE_START_B_I(SAMPLE_START_B_I),
    .CHANNEL_SEL_I(CHANNEL_SEL_I), .SAMPLE_STROBE_O(SAMPLE_STROBE_O), .BUSY_O(BUSY_O),
    .ACTIVE_RATIO_O(ACTIVE_RATIO_O), .RESULT_O(RESULT_O));

// *** tb/tb_top.sv ***
// Testbench: one burst per ratio code, checking length, strobes, latch and averages.
module tb_top
    import osc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [2:0] chan = 3'h0;
    logic strobe;
    logic busy;
    logic start;
    logic [2:0] ratio;
    logic [13:0] result;
    logic [13:0] prev = 14'h0000;
    logic [111:0] data;
    int n_errors = 0;
    int cmp_count = 0;
    int bcnt = 0;
    int scnt = 0;

    ////////////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;

    // Running totals of busy cycles and strobes, read as differences per burst.
    always @(posedge clk)
    begin
        bcnt <= bcnt + int'(busy);
        scnt <= scnt + int'(strobe);
    end

    osc_control i_osc_control (.CLK_I(clk), .RESET_I(rst), .SAMPLE_START_A_I(start),
        .SAMPLE_START_B_I(start), .RATIO_SELECT_I(sel), .SAMPLE_DATA_I(data),
        .CHANNEL_SEL_I(chan), .SAMPLE_STROBE_O(strobe), .BUSY_O(busy),
        .ACTIVE_RATIO_O(ratio), .RESULT_O(result));
    osc_host_model i_osc_host_model (.clk_i(clk), .go_i(go), .busy_i(busy),
        .strobe_i(strobe), .start_o(start), .data_o(data));

    ////////////////////////////////////////////////////////////////////////
    task check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task conclude;
        $display("%0d mismatches in %0d comparisons", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // One burst at the ratio latched before, selecting the next code mid-burst.
    task t_conv(input logic [2:0] nxt, input logic [2:0] cur);
        int b0;
        int s0;
        int k;
        int n;
        n = (cur == OSC_SEL_NONE || cur == OSC_SEL_INVALID) ? 1 : 1 << cur;
        b0 = bcnt;
        s0 = scnt;
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        for (k = 0; k < 20 && busy !== 1'b1; k++) @(negedge clk);
        // A start that never raises busy counts as a mismatch here.
        check(16'(busy), 16'h0001);
        repeat (10) @(negedge clk);
        check(16'(result), 16'(prev));
        @(posedge clk) sel <= nxt;
        for (k = 0; k < 30000 && busy !== 1'b0; k++) @(negedge clk);
        // A burst that never ends counts as a mismatch here.
        check(16'(busy), 16'h0000);
        // Results are read a cycle after busy falls, never on that edge itself.
        @(negedge clk);
        check(16'(bcnt - b0), 16'(n * (OSC_CONV_CYC + 1) - 1));
        check(16'(scnt - s0), 16'(n));
        check(16'(ratio), 16'(nxt));
        for (k = 0; k < OSC_CHANNELS; k++)
        begin
            @(posedge clk) chan <= 3'(k);
            @(negedge clk);
            prev = 14'(k * 256 + 16 + int'(n > 1));
            check(16'(result), 16'(prev));
        end
    endtask : t_conv

    ////////////////////////////////////////////////////////////////////////
    // Scenario: one plain conversion at the reset ratio, selecting ratio 2 meanwhile.
    task t_plain;
        t_conv(3'h1, OSC_SEL_NONE);
    endtask : t_plain

    // Scenario: ratios 2 up to 32 in turn, each selected during the burst before it.
    task t_ratio_sweep;
        int i;
        for (i = 2; i <= 6; i++)
        begin
            t_conv(3'(i), 3'(i - 1));
        end
    endtask : t_ratio_sweep

    // Scenario: ratio 64, then the invalid code, which must behave as no oversampling.
    task t_invalid_code;
        t_conv(OSC_SEL_INVALID, OSC_SEL_MAX);
        t_conv(OSC_SEL_NONE, OSC_SEL_INVALID);
    endtask : t_invalid_code

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        // Codes 1..7 then 0, so every ratio including the invalid one runs once.
        t_plain();
        t_ratio_sweep();
        t_invalid_code();
        conclude();
    end

    // The longest run is about 52k cycles; give it ample margin.
    initial
    begin
        #800000;
        n_errors++;
        conclude();
    end
endmodule : tb_top
